//--- rtl/link_init_pkg.sv
// Constants, register map and state encodings for the host link initialisation machine
package link_init_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;              // 125 MHz local clock
  localparam int unsigned ALIGN_TIMEOUT_NS = 873800;     // 873.8 us align wait
  localparam int unsigned ALIGN_TIMEOUT_CYCLES = ALIGN_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned RETRY_MS = 10;                 // Least recovery poll interval
  localparam int unsigned RETRY_CYCLES = (RETRY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INVALID_MAX_NS = 53;           // Longest invalid signal at speed change
  localparam int unsigned INVALID_CYCLES = INVALID_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 32;                    // State timer width

  // ----------------------------------------------------------------
  // Reset burst grouping and primitive recognition
  // ----------------------------------------------------------------
  localparam logic [2:0] BURST_GROUP = 3'h6;             // Reset bursts go out in sixes
  localparam logic [1:0] NON_ALIGN_NEEDED = 2'h3;        // Back-to-back non-align primitives
  localparam logic [7:0] K28_3 = 8'h7C;                  // Control character in byte 0

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam int unsigned CTRL_RECOVERY_BIT = 0;         // Signal recovery supported
  localparam int unsigned CTRL_RESET_BIT = 1;            // Explicit reset request (level)
  localparam int unsigned CTRL_AUTO_SLUMBER_BIT = 2;     // Partial to deep power allowed
  localparam int unsigned CTRL_CAL_BYPASS_BIT = 3;       // Skip calibration
  localparam logic [3:0] CTRL_RESET_VAL = 4'h0;
  localparam int unsigned STAT_RESUME_BIT = 4;
  localparam int unsigned STAT_WAKE_SEEN_BIT = 5;
  localparam int unsigned STAT_READY_BIT = 6;
  localparam int unsigned STAT_DEV_RESET_BIT = 7;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    host_reset_state, await_init_burst, await_init_release, calibration_state,
    wake_transmit, await_wake, await_wake_release, await_align, speed_adjust,
    send_align, ready_state, partial_power_state, deep_power_state
  } host_state_e;

  typedef enum logic [1:0] {
    device_reset_state, device_init_send, device_run
  } dev_state_e;

endpackage

//--- rtl/host_phy_link_init_fsm.sv
// Host physical layer initialisation state machine with APB control and status
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps

module host_phy_link_init_fsm
  import link_init_pkg::*;
#(
  parameter int unsigned ALIGN_TIMEOUT = ALIGN_TIMEOUT_CYCLES,
  parameter int unsigned RETRY_INTERVAL = RETRY_CYCLES
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Out-of-band detectors (asynchronous)
  input wire logic cominit_det,
  input wire logic comwake_det,
  input wire logic comreset_det,
  input wire logic rx_signal_det,
  // Phy status, local clock
  input wire logic burst_done,
  input wire logic cal_done,
  input wire logic speed_done,
  input wire logic power_recovered,
  input wire logic tx_valid,
  input wire logic align_det,
  input wire logic prim_valid,
  input wire logic [7:0] rx_byte0,
  input wire logic rx_byte0_k,
  // Link layer
  input wire logic partial_req,
  input wire logic slumber_req,
  input wire logic [31:0] link_word,
  // Transmit controls
  output logic tx_comreset,
  output logic tx_comwake,
  output logic tx_d10_2,
  output logic tx_align,
  output logic tx_invalid,
  output logic tx_quiescent,
  output logic [31:0] tx_word,
  output logic cal_start,
  output logic speed_change,
  output logic phy_ready_indication,
  output logic device_init_pulse
);
  import link_init_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers for the asynchronous detectors
  // ----------------------------------------------------------------
  logic [3:0] sync1_q; // First stage, read only by second stage
  logic [3:0] sync2_q; // Safe to use
  logic cominit_s, comwake_s, comreset_s, rx_sig_s;

  // Two flops per detector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= {rx_signal_det, comreset_det, comwake_det, cominit_det};
      sync2_q <= sync1_q;
    end
  end
  assign cominit_s = sync2_q[0];
  assign comwake_s = sync2_q[1];
  assign comreset_s = sync2_q[2];
  assign rx_sig_s = sync2_q[3];

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic [3:0] ctrl_q, ctrl_d; // Control bits
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] status_w; // Live status word
  logic rec_en, reset_req, auto_slumber, cal_bypass;
  logic hit_ctrl, hit_status;

  assign rec_en = ctrl_q[CTRL_RECOVERY_BIT];
  assign reset_req = ctrl_q[CTRL_RESET_BIT];
  assign auto_slumber = ctrl_q[CTRL_AUTO_SLUMBER_BIT];
  assign cal_bypass = ctrl_q[CTRL_CAL_BYPASS_BIT];
  assign hit_ctrl = (paddr == CTRL_ADDR);
  assign hit_status = (paddr == STATUS_ADDR);

  // One wait state: pready rises in the second access cycle
  always_comb
  begin
    ctrl_d = ctrl_q;
    pready_d = psel && penable && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (pready_d)
    begin
      pslverr_d = !(hit_ctrl || hit_status); // Unmapped address
      prdata_d = 32'h0000_0000;
      if (!pwrite && hit_ctrl)
        prdata_d = {28'h000_0000, ctrl_q};
      else if (!pwrite && hit_status)
        prdata_d = status_w;
    end
    if (psel && penable && pready_q && pwrite && hit_ctrl)
      ctrl_d = pwdata[3:0];
  end

  // Bus registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RESET_VAL;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // Host state machine
  // ----------------------------------------------------------------
  host_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d; // Cycles since state entry
  logic [2:0] burst_q, burst_d; // Bursts within the current group of six
  logic group_done_q, group_done_d; // At least one full group sent
  logic [1:0] nonalign_q, nonalign_d; // Consecutive non-align primitives
  logic resume_q, resume_d; // Resume pending
  logic wake_seen_q, wake_seen_d; // COMWAKE during a power state
  logic retry_hit, align_timeout, solicited, nonalign_prim, power_st;

  assign retry_hit = rec_en && (cnt_q >= CNT_W'(RETRY_INTERVAL - 1));
  assign align_timeout = (cnt_q >= CNT_W'(ALIGN_TIMEOUT - 1));
  // Only the init-wait states expect a COMINIT
  assign solicited = (st_q == await_init_burst) || (st_q == await_init_release);
  assign nonalign_prim = prim_valid && rx_byte0_k && (rx_byte0 == K28_3);
  assign power_st = (st_q == partial_power_state) || (st_q == deep_power_state);

  // Next state
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      host_reset_state:
        if (!reset_req && group_done_q && (burst_q == 3'h0))
          st_d = await_init_burst;
      await_init_burst:
        if (cominit_s)
          st_d = await_init_release;
        else if (retry_hit)
          st_d = host_reset_state;
      await_init_release:
        if (!cominit_s)
          st_d = calibration_state;
      calibration_state:
        if (cal_done || cal_bypass)
          st_d = wake_transmit;
      wake_transmit:
        st_d = comwake_s ? await_wake_release : await_wake;
      await_wake:
        if (comwake_s)
          st_d = await_wake_release;
        else if (retry_hit)
          st_d = resume_q ? wake_transmit : host_reset_state;
      await_wake_release:
        if (!comwake_s)
          st_d = await_align;
      await_align:
        if (align_det)
          st_d = speed_adjust;
        else if (align_timeout)
          st_d = host_reset_state;
      speed_adjust:
        if (speed_done && cnt_q >= CNT_W'(INVALID_CYCLES))
          st_d = send_align;
      send_align:
        if (nonalign_prim && nonalign_q == NON_ALIGN_NEEDED - 2'h1)
          st_d = ready_state;
      ready_state:
        if (partial_req)
          st_d = partial_power_state;
        else if (slumber_req)
          st_d = deep_power_state;
        else if (retry_hit && !rx_sig_s)
          st_d = host_reset_state;
      partial_power_state:
        if (!partial_req && power_recovered)
          st_d = (wake_seen_q || comwake_s) ? await_wake_release : wake_transmit;
        else if (slumber_req && auto_slumber)
          st_d = deep_power_state;
      deep_power_state:
        if (!slumber_req && power_recovered)
          st_d = (wake_seen_q || comwake_s) ? await_wake_release : wake_transmit;
    endcase
    // COMINIT reaches every state outside reset
    if (cominit_s && st_q != host_reset_state)
    begin
      if (rec_en && !solicited)
        st_d = host_reset_state;
      else
        st_d = await_init_release;
    end
    if (reset_req)
      st_d = host_reset_state;
  end

  // Timers, counters and flags
  always_comb
  begin
    cnt_d = (st_d != st_q) ? '0 : cnt_q + ((&cnt_q) ? CNT_W'(0) : CNT_W'(1));
    burst_d = burst_q;
    group_done_d = group_done_q;
    if (st_q == host_reset_state && burst_done)
    begin
      // Whole groups of six only
      burst_d = (burst_q == BURST_GROUP - 3'h1) ? 3'h0 : burst_q + 3'h1;
      if (burst_q == BURST_GROUP - 3'h1)
        group_done_d = 1'b1;
    end
    if (st_q != host_reset_state)
    begin
      burst_d = 3'h0;
      group_done_d = 1'b0;
    end
    nonalign_d = 2'h0;
    if (st_q == send_align)
    begin
      if (nonalign_prim)
        nonalign_d = (nonalign_q == NON_ALIGN_NEEDED) ? nonalign_q : nonalign_q + 2'h1;
      else if (!prim_valid)
        nonalign_d = nonalign_q;
    end
    resume_d = resume_q;
    if (rec_en && st_d == host_reset_state)
      resume_d = 1'b0;
    if (rec_en && (st_d == partial_power_state || st_d == deep_power_state))
      resume_d = 1'b1;
    wake_seen_d = wake_seen_q;
    if (!power_st && (st_d == partial_power_state || st_d == deep_power_state))
      wake_seen_d = 1'b0;
    if (power_st && comwake_s)
      wake_seen_d = 1'b1;
  end

  // Host state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= host_reset_state;
      cnt_q <= '0;
      burst_q <= 3'h0;
      group_done_q <= 1'b0;
      nonalign_q <= 2'h0;
      resume_q <= 1'b0;
      wake_seen_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      burst_q <= burst_d;
      group_done_q <= group_done_d;
      nonalign_q <= nonalign_d;
      resume_q <= resume_d;
      wake_seen_q <= wake_seen_d;
    end
  end

  // ----------------------------------------------------------------
  // Device side reset entry
  // ----------------------------------------------------------------
  dev_state_e dst_q, dst_d;

  // COMRESET acts as a hard reset of the device machine
  always_comb
  begin
    dst_d = dst_q;
    unique case (dst_q)
      device_reset_state:
        if (!comreset_s)
          dst_d = device_init_send;
      device_init_send:
        dst_d = device_run;
      device_run:
        dst_d = device_run;
      default:
        dst_d = device_reset_state;
    endcase
    if (comreset_s)
      dst_d = device_reset_state;
  end

  // Device state register; power-on reset is presetn
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dst_q <= device_reset_state;
    else
      dst_q <= dst_d;
  end

  // ----------------------------------------------------------------
  // Registered outputs, decoded from the next state
  // ----------------------------------------------------------------
  logic [9:0] out_q, out_d;
  logic [31:0] tx_word_q, tx_word_d;

  assign status_w = {24'h00_0000, dst_q == device_reset_state, phy_ready_indication,
                     wake_seen_q, resume_q, st_q};

  // Outputs line up with the state register, no decode lag
  always_comb
  begin
    out_d = 10'h000;
    out_d[0] = (st_d == host_reset_state);
    out_d[1] = (st_d == wake_transmit);
    out_d[2] = (st_d == await_align);
    out_d[3] = (st_d == send_align);
    out_d[4] = (st_d == speed_adjust) && (cnt_d < CNT_W'(INVALID_CYCLES));
    out_d[5] = (st_d == await_init_burst) || (st_d == await_init_release) ||
               (st_d == await_wake) || (st_d == await_wake_release) ||
               (st_d == partial_power_state) || (st_d == deep_power_state);
    out_d[6] = (st_d == calibration_state) && !cal_bypass;
    out_d[7] = (st_d == speed_adjust);
    out_d[8] = (st_d == ready_state) && rx_sig_s && tx_valid;
    out_d[9] = (dst_d == device_init_send) && (dst_q != device_init_send);
    tx_word_d = (st_d == ready_state) ? link_word : 32'h0000_0000;
  end

  // Output flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q <= 10'h001;
      tx_word_q <= 32'h0000_0000;
    end
    else
    begin
      out_q <= out_d;
      tx_word_q <= tx_word_d;
    end
  end
  assign tx_comreset = out_q[0];
  assign tx_comwake = out_q[1];
  assign tx_d10_2 = out_q[2];
  assign tx_align = out_q[3];
  assign tx_invalid = out_q[4];
  assign tx_quiescent = out_q[5];
  assign cal_start = out_q[6];
  assign speed_change = out_q[7];
  assign phy_ready_indication = out_q[8];
  assign device_init_pulse = out_q[9];
  assign tx_word = tx_word_q;

endmodule

//--- tb/host_phy_link_init_assertions.sv
// Port-level concurrent checks for the host link initialisation machine
`timescale 1ns/100ps
module host_phy_link_init_assertions #(
  parameter int unsigned ALIGN_TIMEOUT = 50
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Line controls and status
  input wire logic tx_comwake,
  input wire logic tx_d10_2,
  input wire logic tx_align,
  input wire logic tx_invalid,
  input wire logic tx_quiescent,
  input wire logic speed_change,
  input wire logic tx_valid,
  input wire logic phy_ready_indication
);
  int unsigned d10_d; // Next D10.2 run length
  int unsigned d10_q; // Cycles of D10.2 so far

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Helper: length of the current D10.2 run
  // ----------------------------------------
  // A counter, since the align wait is far too long to unroll
  always_comb d10_d = tx_d10_2 ? d10_q + 1 : 0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      d10_q <= 0;
    else
      d10_q <= d10_d;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_invalid_in_adjust;
    tx_invalid |-> speed_change;
  endproperty
  a_invalid_in_adjust: assert property (p_invalid_in_adjust) else $error("invalid signal outside speed change");
  property p_invalid_len;
    $rose(tx_invalid) |-> tx_invalid [*6] ##1 !tx_invalid;
  endproperty
  a_invalid_len: assert property (p_invalid_len) else $error("invalid signal not six cycles");
  property p_wake_one;
    tx_comwake |=> !tx_comwake;
  endproperty
  a_wake_one: assert property (p_wake_one) else $error("wake burst request too long");
  property p_align_from_adjust;
    $rose(tx_align) |-> $past(speed_change);
  endproperty
  a_align_from_adjust: assert property (p_align_from_adjust) else $error("align sent without speed change");
  property p_ready_valid;
    phy_ready_indication |-> $past(tx_valid);
  endproperty
  a_ready_valid: assert property (p_ready_valid) else $error("ready without valid transmit");
  property p_ready_quiet;
    phy_ready_indication |-> !tx_quiescent && !tx_align;
  endproperty
  a_ready_quiet: assert property (p_ready_quiet) else $error("ready outside ready state");
  property p_align_timeout;
    d10_q <= ALIGN_TIMEOUT + 4;
  endproperty
  a_align_timeout: assert property (p_align_timeout) else $error("align wait overran");
  property p_apb_answer;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("bus answer late");
endmodule

bind host_phy_link_init_fsm host_phy_link_init_assertions #(.ALIGN_TIMEOUT(ALIGN_TIMEOUT)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .tx_comwake(tx_comwake), .tx_d10_2(tx_d10_2), .tx_align(tx_align), .tx_invalid(tx_invalid),
  .tx_quiescent(tx_quiescent), .speed_change(speed_change), .tx_valid(tx_valid),
  .phy_ready_indication(phy_ready_indication)
);

//--- tb/dev_phy_model.sv
// Behavioural model of the attached device physical layer
`timescale 1ns/100ps
module dev_phy_model
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host line controls
  input wire logic tx_comreset,
  input wire logic tx_comwake,
  input wire logic tx_d10_2,
  input wire logic tx_align,
  // Scenario control: withhold align
  input wire logic mute,
  // Device to host
  output logic burst_done,
  output logic cominit_det,
  output logic comwake_det,
  output logic align_det,
  output logic prim_valid,
  output logic [7:0] rx_byte0,
  output logic rx_byte0_k
);
  logic [7:0] cnt_q; // Cycles since last host burst
  logic [1:0] ph_q; // Free phase counter
  logic [1:0] mode_q; // 1: owe init burst, 2: owe wake burst

  // Device answers every host burst after a short gap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {cnt_q, ph_q, mode_q, burst_done, cominit_det, comwake_det} <= '0;
      {align_det, prim_valid, rx_byte0, rx_byte0_k} <= '0;
    end
    else
    begin
      ph_q <= ph_q + 2'h1;
      // Counter restarts on each burst so answers follow the latest one
      cnt_q <= (tx_comreset || tx_comwake) ? 8'h00 : cnt_q + 8'(cnt_q != 8'hFF);
      mode_q <= tx_comreset ? 2'h1 : tx_comwake ? 2'h2 : mode_q;
      burst_done <= tx_comreset && ph_q == 2'h3;
      cominit_det <= mode_q == 2'h1 && !tx_comreset && cnt_q > 8'h03 && cnt_q < 8'h0C;
      comwake_det <= mode_q == 2'h2 && cnt_q > 8'h03 && cnt_q < 8'h0C;
      align_det <= !mute && tx_d10_2 && cnt_q > 8'h20;
      prim_valid <= tx_align && ph_q[0];
      rx_byte0_k <= tx_align && ph_q[0];
      // Idle byte toggles so a stale value never looks valid
      rx_byte0 <= (tx_align && ph_q[0]) ? 8'h7C : ~rx_byte0;
    end
  end
endmodule

//--- tb/tb_host_phy_link_init_fsm.sv
// Self-checking bench for the host link initialisation machine
`timescale 1ns/100ps
module tb_host_phy_link_init_fsm;
  import link_init_pkg::*;
  localparam int unsigned AT = 50; // Shortened align timeout
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, mute;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, link_word, tx_word, rd;
  logic cominit_det, comwake_det, rx_signal_det, burst_done, power_recovered, tx_valid;
  logic comreset_det, cal_done, cal_start, device_init_pulse;
  logic align_det, prim_valid, rx_byte0_k, partial_req, slumber_req;
  logic [7:0] rx_byte0;
  logic tx_comreset, tx_comwake, tx_d10_2, tx_align, tx_quiescent, phy_ready_indication;
  int n_errors = 0;
  int checks = 0;
  int n;

  // Block under test, long counts shortened
  host_phy_link_init_fsm #(.ALIGN_TIMEOUT(AT), .RETRY_INTERVAL(100)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cominit_det(cominit_det),
    .comwake_det(comwake_det), .comreset_det(comreset_det), .rx_signal_det(rx_signal_det),
    .burst_done(burst_done), .cal_done(cal_done), .speed_done(1'b1), .power_recovered(power_recovered),
    .tx_valid(tx_valid),
    .align_det(align_det), .prim_valid(prim_valid), .rx_byte0(rx_byte0), .rx_byte0_k(rx_byte0_k),
    .partial_req(partial_req), .slumber_req(slumber_req), .link_word(link_word), .tx_comreset(tx_comreset),
    .tx_comwake(tx_comwake), .tx_d10_2(tx_d10_2), .tx_align(tx_align), .tx_invalid(),
    .tx_quiescent(tx_quiescent), .tx_word(tx_word), .cal_start(cal_start), .speed_change(),
    .phy_ready_indication(phy_ready_indication), .device_init_pulse(device_init_pulse)
  );

  // Far side device
  dev_phy_model u_dev (
    .pclk(pclk), .presetn(presetn), .tx_comreset(tx_comreset), .tx_comwake(tx_comwake),
    .tx_d10_2(tx_d10_2), .tx_align(tx_align), .mute(mute), .burst_done(burst_done),
    .cominit_det(cominit_det), .comwake_det(comwake_det), .align_det(align_det),
    .prim_valid(prim_valid), .rx_byte0(rx_byte0), .rx_byte0_k(rx_byte0_k)
  );

  always #4 pclk = ~pclk;

  // One bus transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compare and count
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      n_errors++;
  endtask

  // Bounded wait for the link to come up
  task automatic wait_ready();
    for (n = 0; n < 1000 && phy_ready_indication !== 1'b1; n++)
      @(posedge pclk);
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: whole run needs under a thousand cycles
  initial
  begin
    #100000;
    n_errors++;
    print_verdict();
  end

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, mute, partial_req, slumber_req, power_recovered} = '0;
    {tx_valid, rx_signal_det, paddr, pwdata} = {2'h3, 12'h000, 32'h0};
    link_word = 32'h0;
    {comreset_det, cal_done} = 2'h1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Explicit reset held, calibration bypassed
    apb(1'b1, CTRL_ADDR, 32'h0000000A);
    repeat (60) @(posedge pclk);
    chk(tx_comreset, 1'b1);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd[3:0], 4'(host_reset_state));
    apb(1'b0, 12'h0FC, 32'h0);
    chk({er, rd}, 33'h100000000);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000000A);
    // Device side: COMRESET holds its machine in reset, release sends one init pulse
    comreset_det <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd[7], 1'b1);
    comreset_det <= 1'b0;
    for (n = 0; n < 10 && device_init_pulse !== 1'b1; n++)
      @(posedge pclk);
    chk(device_init_pulse, 1'b1);
    @(posedge pclk);
    chk(device_init_pulse, 1'b0);
    // Release with recovery supported
    apb(1'b1, CTRL_ADDR, 32'h00000009);
    wait_ready();
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd[6:0], {3'h4, 4'(ready_state)});
    link_word <= 32'hA5C30F96;
    repeat (3) @(posedge pclk);
    chk(tx_word, 32'hA5C30F96);
    tx_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(phy_ready_indication, 1'b0);
    tx_valid <= 1'b1;
    wait_ready();
    // Partial then deep power, each left late and then recovered
    for (int i = 0; i < 2; i++)
    begin
      power_recovered <= 1'b0;
      partial_req <= (i == 0);
      slumber_req <= (i == 1);
      repeat (10) @(posedge pclk);
      chk(tx_quiescent, 1'b1);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk(rd[4:0], 5'h1B + 5'(i));
      partial_req <= 1'b0;
      slumber_req <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk(rd[3:0], 4'hB + 4'(i));
      power_recovered <= 1'b1;
      wait_ready();
      chk(phy_ready_indication, 1'b1);
    end
    // Recovery poll: received signal lost in ready ends in reset after the poll interval
    rx_signal_det <= 1'b0;
    for (n = 0; n < 200 && tx_comreset !== 1'b1; n++)
      @(posedge pclk);
    chk(n >= 90 && tx_comreset === 1'b1, 1'b1);
    rx_signal_det <= 1'b1;
    // Device withholds align: wait must end in reset
    // Calibration runs this time and holds until done
    mute <= 1'b1;
    cal_done <= 1'b0;
    apb(1'b1, CTRL_ADDR, 32'h0000000A);
    apb(1'b1, CTRL_ADDR, 32'h00000000);
    for (n = 0; n < 500 && cal_start !== 1'b1; n++)
      @(posedge pclk);
    repeat (5) @(posedge pclk);
    chk({cal_start, tx_comwake}, 2'h2);
    cal_done <= 1'b1;
    for (n = 0; n < 500 && tx_d10_2 !== 1'b1; n++)
      @(posedge pclk);
    for (n = 0; n < AT + 20 && tx_d10_2 === 1'b1; n++)
      @(posedge pclk);
    chk(n >= AT - 2 && tx_comreset === 1'b1, 1'b1);
    mute <= 1'b0;
    wait_ready();
    chk(phy_ready_indication, 1'b1);
    print_verdict();
  end
endmodule
